/* File: rtl/dsps_defs.vh */
// Purpose: Shared offsets, field positions and reset values for the
//          converter sync and PLL status register bank.
// Assumes: 8-bit registers on an 8-bit register address.
// Notes:   Definitions only.
`ifndef DSPS_DEFS_VH
`define DSPS_DEFS_VH

`define DSPS_ADDR_LOOP_DIV 8'h0d
`define DSPS_ADDR_PLL_STAT 8'h0e
`define DSPS_ADDR_BAND_STAT 8'h0f
`define DSPS_ADDR_SYNC_CFG 8'h10
`define DSPS_ADDR_PHASE_TGT 8'h11
`define DSPS_ADDR_SYNC_FLAGS 8'h12
`define DSPS_ADDR_PHASE_MEAS 8'h13

`define DSPS_PLL_LOCK_BIT 7
`define DSPS_CFG_EN_BIT 7
`define DSPS_CFG_RATE_BIT 6
`define DSPS_CFG_EDGE_BIT 3
`define DSPS_FLAG_LOST_BIT 7
`define DSPS_FLAG_LOCKED_BIT 6

`define DSPS_RST_LOOP_DIV 2'h1
`define DSPS_RST_SYNC_CFG 8'h48
`define DSPS_RST_PHASE_TGT 6'h00

`define DSPS_RATIO_00 5'h02
`define DSPS_RATIO_01 5'h04
`define DSPS_RATIO_10 5'h08
`define DSPS_RATIO_11 5'h10

`define DSPS_PHASE_PERIOD 7'h40

`endif

/* File: rtl/dsps_phase_avg.v */
// Purpose: Averages measured sync phases over a power-of-two window.
// Assumes: One sample per sample_valid pulse, 6-bit integer phase.
// Notes:   Result in 6.2 format, one pulse of avg_valid per window.
`timescale 1ns/1ps
module dsps_phase_avg #(
    parameter MAX_CODE = 7
) (
    clk,
    rst,
    clear,
    sample_valid,
    sample,
    avg_code,
    avg_valid,
    avg_q
);
    input wire clk;
    input wire rst;
    input wire clear;
    input wire sample_valid;
    input wire [5:0] sample;
    input wire [2:0] avg_code;
    output reg avg_valid;
    output reg [7:0] avg_q;

    reg [12:0] sum_q;
    reg [6:0] cnt_q;
    wire [12:0] sum_next;
    wire [6:0] cnt_last;
    wire [14:0] scaled;

    assign sum_next = sum_q + {7'h00, sample};
    // Window length is two to the code, code 000 being one sample
    assign cnt_last = (7'h01 << avg_code) - 7'h01;
    // Two extra bits before the shift keep the quarter-cycle fraction
    assign scaled = {sum_next, 2'b00} >> avg_code;

    always @(posedge clk) begin
        if (rst || clear) begin
            sum_q <= 13'h0000;
            cnt_q <= 7'h00;
            avg_valid <= 1'b0;
            avg_q <= 8'h00;
        end else begin
            avg_valid <= 1'b0;
            if (sample_valid) begin
                if (cnt_q >= cnt_last) begin
                    sum_q <= 13'h0000;
                    cnt_q <= 7'h00;
                    avg_valid <= 1'b1;
                    avg_q <= scaled[7:0];
                end else begin
                    sum_q <= sum_next;
                    cnt_q <= cnt_q + 7'h01;
                end
            end
        end
    end
endmodule

/* File: rtl/dsps_top.v */
// Purpose: Sync control/status and PLL status registers for a converter.
// Assumes: Serial-port core delivers decoded byte accesses on this port;
//          all inputs synchronous to the sample clock clk.
// Notes:   Sync edges are expected on multiples of the 64-cycle frame.
// What this block does
// - Loop divider codes 01, 10, 11 give ratios 4, 8, 16.
// - Loop divider code 00 gives ratio 2.
// - PLL status bit 7 reads lock while PLL tracks the reference clock.
// - PLL status low four bits read oscillator control voltage.
// - Second PLL status register reads six-bit oscillator band.
// - Sync runs only while config bit 7 is one; off after reset.
// - Config bit 6 picks FIFO reset rate (0) or data rate (1).
// - Config bit 3 picks falling (0) or rising (1) sync edge.
// - Averaging code sets two to the code samples per average.
// - Phase target sets output offset after sync, 0 to 63 cycles.
// - Flags bit 6 is set once synchronization is attained.
// - Flags bit 7 is set when attained sync is later lost.
// - Measured phase reads as unsigned 6.2, step of a quarter cycle.
`timescale 1ns/1ps
`include "dsps_defs.vh"
module dsps_top (
    clk,
    rst,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    reg_rvalid,
    pll_lock_in,
    vco_voltage_in,
    vco_band_in,
    sync_in,
    fifo_rate_tick,
    loop_divider_ratio,
    frame_start,
    sync_locked,
    sync_lost
);
    input wire clk;
    input wire rst;
    input wire [7:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_wr;
    input wire reg_rd;
    output reg [7:0] reg_rdata;
    output reg reg_rvalid;
    input wire pll_lock_in;
    input wire [3:0] vco_voltage_in;
    input wire [5:0] vco_band_in;
    input wire sync_in;
    input wire fifo_rate_tick;
    output reg [4:0] loop_divider_ratio;
    output reg frame_start;
    output wire sync_locked;
    output wire sync_lost;

    function [4:0] dsps_ratio;
        input [1:0] code;
        begin
            case (code)
                2'h0: dsps_ratio = `DSPS_RATIO_00;
                2'h1: dsps_ratio = `DSPS_RATIO_01;
                2'h2: dsps_ratio = `DSPS_RATIO_10;
                default: dsps_ratio = `DSPS_RATIO_11;
            endcase
        end
    endfunction

    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg [1:0] loop_div_q;
    reg [7:0] sync_cfg_q;
    reg [5:0] phase_tgt_q;
    reg pll_lock_q;
    reg [3:0] vco_volt_q;
    reg [5:0] vco_band_q;
    reg sync_prev_q;
    reg state_q;
    reg [5:0] frame_cnt_q;
    reg locked_q;
    reg lost_q;
    reg [7:0] meas_q;
    reg meas_valid_q;
    reg [5:0] meas_phase_q;

    wire sync_en;
    wire rate_data;
    wire edge_rise;
    wire edge_seen;
    wire edge_qual;
    wire avg_valid;
    wire [7:0] avg_val;
    wire [5:0] phase_now;

    assign sync_en = sync_cfg_q[`DSPS_CFG_EN_BIT];
    assign rate_data = sync_cfg_q[`DSPS_CFG_RATE_BIT];
    assign edge_rise = sync_cfg_q[`DSPS_CFG_EDGE_BIT];
    assign edge_seen = edge_rise ? (sync_in && !sync_prev_q)
                                 : (!sync_in && sync_prev_q);
    // FIFO rate mode only honours edges that coincide with a FIFO reset
    assign edge_qual = sync_en && edge_seen
                       && (rate_data || fifo_rate_tick);
    // Offset of the edge from the frame, equals target when aligned
    assign phase_now = phase_tgt_q - frame_cnt_q;
    assign sync_locked = locked_q;
    assign sync_lost = lost_q;

    // Software-writable registers; status addresses ignore writes
    always @(posedge clk) begin
        if (rst) begin
            loop_div_q <= `DSPS_RST_LOOP_DIV;
            sync_cfg_q <= `DSPS_RST_SYNC_CFG;
            phase_tgt_q <= `DSPS_RST_PHASE_TGT;
        end else if (reg_wr) begin
            case (reg_addr)
                `DSPS_ADDR_LOOP_DIV: loop_div_q <= reg_wdata[1:0];
                `DSPS_ADDR_SYNC_CFG: sync_cfg_q <= reg_wdata & 8'hcf;
                `DSPS_ADDR_PHASE_TGT: phase_tgt_q <= reg_wdata[5:0];
                default: loop_div_q <= loop_div_q;
            endcase
        end
    end

    // Status inputs are sampled every cycle so reads show live state
    always @(posedge clk) begin
        if (rst) begin
            pll_lock_q <= 1'b0;
            vco_volt_q <= 4'h0;
            vco_band_q <= 6'h00;
            loop_divider_ratio <= `DSPS_RATIO_01;
        end else begin
            pll_lock_q <= pll_lock_in;
            vco_volt_q <= vco_voltage_in;
            vco_band_q <= vco_band_in;
            loop_divider_ratio <= dsps_ratio(loop_div_q);
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `DSPS_ADDR_LOOP_DIV:
                        reg_rdata <= {6'h00, loop_div_q};
                    `DSPS_ADDR_PLL_STAT:
                        reg_rdata <= {pll_lock_q, 3'h0, vco_volt_q};
                    `DSPS_ADDR_BAND_STAT:
                        reg_rdata <= {2'h0, vco_band_q};
                    `DSPS_ADDR_SYNC_CFG:
                        reg_rdata <= sync_cfg_q;
                    `DSPS_ADDR_PHASE_TGT:
                        reg_rdata <= {2'h0, phase_tgt_q};
                    `DSPS_ADDR_SYNC_FLAGS:
                        reg_rdata <= {lost_q, locked_q, 6'h00};
                    `DSPS_ADDR_PHASE_MEAS:
                        reg_rdata <= meas_q;
                    default:
                        reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    // First qualified edge aligns the frame; later edges are measured
    always @(posedge clk) begin
        if (rst) begin
            sync_prev_q <= 1'b0;
            state_q <= ST_IDLE;
            frame_cnt_q <= 6'h00;
            frame_start <= 1'b0;
            meas_valid_q <= 1'b0;
            meas_phase_q <= 6'h00;
        end else begin
            sync_prev_q <= sync_in;
            frame_cnt_q <= frame_cnt_q + 6'h01;
            frame_start <= sync_en && state_q == ST_RUN
                           && frame_cnt_q == phase_tgt_q;
            meas_valid_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (edge_qual) begin
                        frame_cnt_q <= 6'h01;
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!sync_en) begin
                        state_q <= ST_IDLE;
                    end else if (edge_qual) begin
                        meas_valid_q <= 1'b1;
                        meas_phase_q <= phase_now;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    dsps_phase_avg #(
        .MAX_CODE(7)
    ) u_avg (
        .clk(clk),
        .rst(rst),
        .clear(!sync_en),
        .sample_valid(meas_valid_q),
        .sample(meas_phase_q),
        .avg_code(sync_cfg_q[2:0]),
        .avg_valid(avg_valid),
        .avg_q(avg_val)
    );

    // Lost is sticky until sync is disabled; a loss beats any clearing
    always @(posedge clk) begin
        if (rst) begin
            locked_q <= 1'b0;
            lost_q <= 1'b0;
            meas_q <= 8'h00;
        end else if (avg_valid) begin
            meas_q <= avg_val;
            if (avg_val == {phase_tgt_q, 2'b00}) begin
                locked_q <= 1'b1;
            end else if (locked_q) begin
                locked_q <= 1'b0;
                lost_q <= 1'b1;
            end
        end else if (!sync_en) begin
            locked_q <= 1'b0;
            lost_q <= 1'b0;
        end
    end
endmodule

/* File: testbench/dsps_sync_src.sv */
// Purpose: External sync source for the converter sync logic.
// Assumes: Free-running 64-cycle frame, active edge at phase 0.
// Notes: Idles low while go is low; slip delays later edges by one.
`timescale 1ns/1ps
module dsps_sync_src (
    input wire clk,
    input wire go,
    input wire fall,
    input wire slip,
    output reg [5:0] ph_q,
    output wire sync_in
);
    initial ph_q = 6'h00;
    always @(posedge clk) begin
        if (!slip) begin
            ph_q <= ph_q + 6'h01;
        end
    end
    // Falling mode puts the falling edge on phase 0 as well
    assign sync_in = go & ((ph_q < 6'h20) ^ fall);
endmodule

/* File: testbench/dsps_top_chk.sv */
// Purpose: Port checks of the sync and PLL status bank.
// Assumes: Flag outputs and flag register are the same state.
// Notes: Bound to dsps_top.
`timescale 1ns/1ps
module dsps_top_chk (
    input wire clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    input wire pll_lock_in,
    input wire [3:0] vco_voltage_in,
    input wire [5:0] vco_band_in,
    input wire [4:0] loop_divider_ratio,
    input wire frame_start,
    input wire sync_locked,
    input wire sync_lost
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    AST_RVALID: assert property (
        !$past(rst) |-> reg_rvalid == $past(reg_rd))
        else $error("read answer misplaced");
    AST_RDATA_HOLD: assert property (
        !$past(rst) && !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    AST_PLL_READ: assert property (
        reg_rd && reg_addr == 8'h0e && !$past(rst) && $stable(pll_lock_in)
        && $stable(vco_voltage_in) |=> reg_rdata[7] == $past(pll_lock_in)
        && reg_rdata[3:0] == $past(vco_voltage_in))
        else $error("pll status read wrong");
    AST_BAND_READ: assert property (
        reg_rd && reg_addr == 8'h0f && !$past(rst) && $stable(vco_band_in)
        |=> reg_rdata[5:0] == $past(vco_band_in))
        else $error("band read wrong");
    AST_FLAG_READ: assert property (
        reg_rd && reg_addr == 8'h12
        |=> reg_rdata[7:6] == {$past(sync_lost), $past(sync_locked)})
        else $error("flag read differs from flag outputs");
    AST_RATIO_WRITE: assert property (
        reg_wr && reg_addr == 8'h0d ##1 !reg_wr |-> ##1
        loop_divider_ratio == 5'h02 << $past(reg_wdata[1:0], 2))
        else $error("ratio does not follow divider code");
    AST_LOST_AFTER_LOCK: assert property (
        $rose(sync_lost) |-> $past(sync_locked))
        else $error("lost without prior lock");
    AST_LOST_CLEAR: assert property (
        $fell(sync_lost) && !$past(rst)
        |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
        else $error("lost flag cleared by itself");
    AST_FRAME_PULSE: assert property (
        frame_start |=> !frame_start)
        else $error("frame pulse too long");
endmodule
bind dsps_top dsps_top_chk chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pll_lock_in(pll_lock_in),
    .vco_voltage_in(vco_voltage_in), .vco_band_in(vco_band_in),
    .loop_divider_ratio(loop_divider_ratio), .frame_start(frame_start),
    .sync_locked(sync_locked), .sync_lost(sync_lost));

/* File: testbench/test_dac_sync_and_pll_status.sv */
// Purpose: Self-checking bench for the sync and PLL status bank.
// Assumes: Sync source frame of 64 cycles, inputs driven 1 ns after edge.
// Notes: Averaging code 7 needs about 8200 cycles to lock.
`timescale 1ns/1ps
module test_dac_sync_and_pll_status;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg pll_lock_in = 1'b0;
    reg [3:0] vco_voltage_in = 4'h0;
    reg [5:0] vco_band_in = 6'h00;
    reg fifo_rate_tick = 1'b1;
    reg go = 1'b0;
    reg fall = 1'b0;
    reg slip = 1'b0;
    reg [5:0] ph;
    reg [5:0] ph0;
    integer lk;
    integer fail_count = 0;
    integer samples_checked = 0;
    wire [7:0] reg_rdata;
    wire [4:0] ratio;
    wire [5:0] src_ph;
    wire reg_rvalid, frame_start, sync_locked, sync_lost, sync_in;
    always #2 clk = ~clk;
    dsps_sync_src src_u (.clk(clk), .go(go), .fall(fall), .slip(slip),
        .ph_q(src_ph), .sync_in(sync_in));
    dsps_top dut_u (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .pll_lock_in(pll_lock_in), .vco_voltage_in(vco_voltage_in),
        .vco_band_in(vco_band_in), .sync_in(sync_in),
        .fifo_rate_tick(fifo_rate_tick), .loop_divider_ratio(ratio),
        .frame_start(frame_start), .sync_locked(sync_locked),
        .sync_lost(sync_lost));
    task step;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task chk(input string nm, input [7:0] got, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD %s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            step;
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            step;
            reg_wr = 1'b0;
        end
    endtask
    task rc(input [7:0] a, input [7:0] e);
        begin
            step;
            reg_addr = a;
            reg_rd = 1'b1;
            step;
            reg_rd = 1'b0;
            chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
            chk("rdata", reg_rdata, e);
        end
    endtask
    task t_defaults;
        begin
            rc(8'h0d, 8'h01);
            rc(8'h10, 8'h48);
            rc(8'h11, 8'h00);
            rc(8'h12, 8'h00);
            rc(8'h20, 8'h00);
            chk("ratio", {3'h0, ratio}, 8'h04);
            $display("t_defaults done");
        end
    endtask
    task t_ratio;
        integer c;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                wr(8'h0d, c[7:0]);
                step;
                step;
                chk("ratio", {3'h0, ratio}, 8'h02 << c);
            end
            $display("t_ratio done");
        end
    endtask
    task t_status;
        begin
            pll_lock_in = 1'b1;
            vco_voltage_in = 4'ha;
            vco_band_in = 6'h2d;
            wr(8'h0e, 8'h75);
            wr(8'h0f, 8'h12);
            wr(8'h12, 8'hff);
            rc(8'h0e, 8'h8a);
            rc(8'h0f, 8'h2d);
            rc(8'h12, 8'h00);
            pll_lock_in = 1'b0;
            vco_voltage_in = 4'h5;
            rc(8'h0e, 8'h05);
            $display("t_status done");
        end
    endtask
    task run_sync(input [7:0] cfg, input tk, input fl, input [5:0] tg,
        input ex);
        integer i;
        begin
            wr(8'h10, 8'h48);
            fifo_rate_tick = tk;
            fall = fl;
            go = 1'b1;
            wr(8'h11, {2'h0, tg});
            // Enable away from the frame edge so alignment is clean
            for (i = 0; src_ph !== 6'h28 && i < 70; i = i + 1) step;
            wr(8'h10, cfg);
            for (lk = 0; sync_locked !== 1'b1 && lk < (ex ? 9000 : 400);
                lk = lk + 1) step;
            chk("locked", {7'h0, sync_locked}, {7'h0, ex});
            if (ex) begin
                rc(8'h13, {tg, 2'h0});
                rc(8'h12, 8'h40);
                for (i = 0; frame_start !== 1'b1 && i < 70; i = i + 1) step;
                ph = src_ph;
                step;
                for (i = 1; frame_start !== 1'b1 && i < 70; i = i + 1) step;
                chk("period", i[7:0], 8'h40);
            end
        end
    endtask
    task t_modes;
        begin
            run_sync(8'h48, 1'b1, 1'b0, 6'h05, 1'b0);
            run_sync(8'h88, 1'b0, 1'b0, 6'h05, 1'b0);
            run_sync(8'h88, 1'b1, 1'b0, 6'h05, 1'b1);
            $display("t_modes done");
        end
    endtask
    task t_codes;
        integer c;
        begin
            // Data rate with the FIFO tick held low: every edge must count
            for (c = 0; c < 8; c = c + 1) begin
                run_sync(8'hc0 | c[7:0] | {4'h0, c[0], 3'h0}, 1'b0,
                    ~c[0], c[5:0] * 6'h09, 1'b1);
                if (c == 0) ph0 = ph;
                chk("offset", {2'h0, ph - ph0},
                    {2'h0, c[5:0] * 6'h09});
                chk("avg", {7'h0, lk >= (64 << c) && lk < (64 << c) + 90},
                    8'h01);
            end
            $display("t_codes done");
        end
    endtask
    task t_lost;
        integer i;
        begin
            run_sync(8'hc8, 1'b1, 1'b0, 6'h05, 1'b1);
            slip = 1'b1;
            step;
            slip = 1'b0;
            for (i = 0; sync_lost !== 1'b1 && i < 300; i = i + 1) step;
            chk("lost", {7'h0, sync_lost}, 8'h01);
            chk("unlocked", {7'h0, sync_locked}, 8'h00);
            rc(8'h12, 8'h80);
            rc(8'h13, 8'h10);
            wr(8'h10, 8'h48);
            rc(8'h12, 8'h00);
            chk("lost off", {7'h0, sync_lost}, 8'h00);
            $display("t_lost done");
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        t_defaults;
        t_ratio;
        t_status;
        t_modes;
        t_codes;
        t_lost;
        report_and_stop;
    end
    initial begin
        // About 20k cycles are needed; 50k leaves room before giving up
        #200000;
        fail_count = fail_count + 1;
        report_and_stop;
    end
endmodule
